// ==== core/blm_ctrl.sv ====
// front-panel led and push-button mode controller with apb registers
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "blm_map.svh"
module blm_ctrl
  import blm_pkg::*;
#(
  parameter int TICK_CYCLES = `BLM_CLK_HZ / `BLM_MS_PER_S,
  parameter int POWERUP_MS = `BLM_POWERUP_S * `BLM_MS_PER_S,
  parameter int TEST_MS = `BLM_TEST_TIMEOUT_MIN * `BLM_S_PER_MIN * `BLM_MS_PER_S,
  parameter int LEARN_MS = `BLM_LEARN_TIMEOUT_MIN * `BLM_S_PER_MIN * `BLM_MS_PER_S,
  parameter int STEP_MS = `BLM_STEP_MS,
  parameter int FLASH_MS = `BLM_FLASH_MS,
  parameter int READY_FLASH_MS = `BLM_READY_FLASH_MS,
  parameter int LEARN_OK_MS = `BLM_LEARN_OK_MS,
  parameter int RESTORE_MS = `BLM_RESTORE_MS,
  parameter int DEB_MS = `BLM_DEBOUNCE_MS
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic push_btn_n, // push button pin, low pressed
  input wire logic restore_btn_n, // restore button pin, low pressed
  input wire logic sensor_pin, // presence sensor pin
  input wire logic decode_ok, // pulse per good decode
  input wire logic no_read, // pulse per no-read
  input wire logic tx_active, // main serial port sending
  input wire logic learn_saved, // pulse when learned params saved
  input wire logic factory_ok, // pulse when factory defaults done
  output logic led_ready, // ready / netconfig led
  output logic led_good, // good / setup led
  output logic led_trigger, // trigger / learn led
  output logic led_com, // com / test led
  output logic led_status, // status led
  output logic test_active, // read-rate test running
  output logic learn_active, // code learning running
  output logic learn_discard, // pulse, learned params dropped
  output logic setup_port_only, // chain traffic off on open port
  output logic netcfg_scan, // discover slaves on the chain
  output logic restore_req, // pulse, adopt box parameters
  output logic recovery_mode, // software recovery entered
  output logic factory_req // factory default reset requested
);
  // ==========================================
  // helpers
  function automatic logic expired(input logic [17:0] c, input int lim);
    return c >= 18'(lim - 1);
  endfunction

  function automatic logic [4:0] bar(input logic [6:0] r);
    logic [4:0] b;
    b = '0;
    for (int i = 0; i < 5; i++) begin
      b[i] = r > 7'(i * `BLM_BAR_STEP);
    end
    return b;
  endfunction

  // ==========================================
  // ms tick and button inputs
  logic [15:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic push, rest, push_q_ff, press;
  logic sens1_ff, sens2_ff;

  always_comb begin
    nxt_div = div_ff + 16'h0001;
    nxt_tick = 1'b0;
    if (div_ff >= 16'(TICK_CYCLES - 1)) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
      push_q_ff <= 1'b0;
      sens1_ff <= 1'b0;
      sens2_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      push_q_ff <= push;
      sens1_ff <= sensor_pin;
      sens2_ff <= sens1_ff;
    end
  end

  assign press = push & ~push_q_ff;

  blm_debounce #(.DEB_MS(DEB_MS)) u_push_deb (
    .pclk(pclk),
    .presetn(presetn),
    .tick_ms(tick_ff),
    .pin_n(push_btn_n),
    .held(push)
  );

  blm_debounce #(.DEB_MS(DEB_MS)) u_rest_deb (
    .pclk(pclk),
    .presetn(presetn),
    .tick_ms(tick_ff),
    .pin_n(restore_btn_n),
    .held(rest)
  );

  // ==========================================
  // apb registers
  logic [`BLM_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [`BLM_RATE_W-1:0] rate_ff, nxt_rate;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] status_w;
  logic hit, setup_ph;
  blm_state_t state_ff, nxt_state;
  blm_step_t step_ff, nxt_step;
  logic [4:0] led_ff, nxt_led;

  assign hit = paddr == `BLM_OFS_CTRL || paddr == `BLM_OFS_RATE || paddr == `BLM_OFS_STATUS;
  assign setup_ph = psel & ~penable;

  always_comb begin
    status_w = '0;
    status_w[`BLM_ST_STATE_LSB +: 4] = state_ff;
    status_w[`BLM_ST_LED_LSB +: 5] = led_ff;
    status_w[`BLM_ST_PUSH] = push;
    status_w[`BLM_ST_RESTORE] = rest;
    status_w[`BLM_ST_STEP_LSB +: 3] = step_ff;
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rate = rate_ff;
    nxt_rdata = rdata_ff;
    if (psel && penable && pwrite) begin
      if (paddr == `BLM_OFS_CTRL) begin
        nxt_ctrl = pwdata[`BLM_CTRL_W-1:0];
      end
      if (paddr == `BLM_OFS_RATE) begin
        nxt_rate = pwdata[`BLM_RATE_W-1:0];
      end
    end
    if (setup_ph && !pwrite) begin
      case (paddr)
        `BLM_OFS_CTRL: nxt_rdata = {27'h0000000, ctrl_ff};
        `BLM_OFS_RATE: nxt_rdata = {25'h0000000, rate_ff};
        `BLM_OFS_STATUS: nxt_rdata = status_w;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `BLM_CTRL_RST;
      rate_ff <= '0;
      rdata_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rate_ff <= nxt_rate;
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // ==========================================
  // blink phase and event stretchers
  logic [17:0] fl_cnt_ff, nxt_fl_cnt;
  logic blink_ff, nxt_blink;
  logic [17:0] good_cnt_ff, nxt_good_cnt, nr_cnt_ff, nxt_nr_cnt;
  logic noread_ff, nxt_noread;

  always_comb begin
    nxt_fl_cnt = fl_cnt_ff;
    nxt_blink = blink_ff;
    nxt_good_cnt = good_cnt_ff;
    nxt_nr_cnt = nr_cnt_ff;
    nxt_noread = noread_ff;
    if (tick_ff) begin
      nxt_fl_cnt = fl_cnt_ff + 18'h00001;
      if (expired(fl_cnt_ff, FLASH_MS)) begin
        nxt_fl_cnt = '0;
        nxt_blink = ~blink_ff;
      end
      if (good_cnt_ff != '0) begin
        nxt_good_cnt = good_cnt_ff - 18'h00001;
      end
      if (nr_cnt_ff != '0) begin
        nxt_nr_cnt = nr_cnt_ff - 18'h00001;
      end
    end
    if (decode_ok) begin
      nxt_good_cnt = 18'(FLASH_MS);
      nxt_noread = 1'b0;
    end
    if (no_read) begin
      nxt_nr_cnt = 18'(FLASH_MS);
      nxt_noread = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_cnt_ff <= '0;
      blink_ff <= 1'b0;
      good_cnt_ff <= '0;
      nr_cnt_ff <= '0;
      noread_ff <= 1'b0;
    end else begin
      fl_cnt_ff <= nxt_fl_cnt;
      blink_ff <= nxt_blink;
      good_cnt_ff <= nxt_good_cnt;
      nr_cnt_ff <= nxt_nr_cnt;
      noread_ff <= nxt_noread;
    end
  end

  // ==========================================
  // mode state machine
  logic [17:0] ms_cnt_ff, nxt_ms_cnt;
  logic [2:0] nfl_ff, nxt_nfl;
  logic discard_ff, nxt_discard, restq_ff, nxt_restq;
  logic ptslave;

  assign ptslave = ctrl_ff[`BLM_CTRL_TRACK_MODE] & ctrl_ff[`BLM_CTRL_SLAVE];

  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_nfl = nfl_ff;
    nxt_discard = 1'b0;
    nxt_restq = 1'b0;
    nxt_ms_cnt = tick_ff ? ms_cnt_ff + 18'h00001 : ms_cnt_ff;
    case (state_ff)
      ST_POWERUP: begin
        if (tick_ff && expired(ms_cnt_ff, POWERUP_MS)) begin
          if (push && rest) begin
            nxt_state = ST_FACTORY;
          end else if (push) begin
            nxt_state = ST_RECOVERY;
          end else begin
            nxt_state = ST_READY_FLASH;
          end
        end
      end
      ST_READY_FLASH: begin
        if (tick_ff && expired(ms_cnt_ff, READY_FLASH_MS)) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (press) begin
          nxt_state = ST_HOLD;
          nxt_step = STEP_EXIT;
        end else if (rest) begin
          nxt_state = ST_RESTORE;
        end
      end
      ST_HOLD: begin
        if (!push) begin
          case (step_ff)
            STEP_TEST: nxt_state = ST_TEST;
            STEP_LEARN: nxt_state = ST_LEARN;
            STEP_SETUP: nxt_state = ST_SETUP;
            STEP_NETCFG: nxt_state = ctrl_ff[`BLM_CTRL_MASTER] ? ST_NETCFG : ST_RUN;
            default: nxt_state = ST_RUN;
          endcase
        end else if (tick_ff && expired(ms_cnt_ff, STEP_MS)) begin
          nxt_ms_cnt = '0;
          case (step_ff)
            STEP_EXIT: nxt_step = STEP_TEST;
            STEP_TEST: nxt_step = STEP_LEARN;
            STEP_LEARN: nxt_step = STEP_SETUP;
            STEP_SETUP: nxt_step = STEP_NETCFG;
            default: nxt_step = STEP_EXIT;
          endcase
        end
      end
      ST_TEST: begin
        if (press || (tick_ff && expired(ms_cnt_ff, TEST_MS))) begin
          nxt_state = ST_RUN;
        end
      end
      ST_LEARN: begin
        if (learn_saved) begin
          nxt_state = ST_LEARN_OK;
        end else if (tick_ff && expired(ms_cnt_ff, LEARN_MS)) begin
          nxt_state = ST_RUN;
          nxt_discard = 1'b1;
        end
      end
      ST_LEARN_OK: begin
        if (tick_ff && expired(ms_cnt_ff, LEARN_OK_MS)) begin
          nxt_state = ST_RUN;
        end
      end
      ST_SETUP, ST_NETCFG: begin
        if (press) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RESTORE: begin
        if (tick_ff && expired(ms_cnt_ff, RESTORE_MS)) begin
          nxt_ms_cnt = '0;
          nxt_nfl = nfl_ff + 3'h1;
          if (nfl_ff == 3'h1) begin
            nxt_state = ST_RUN;
            nxt_restq = 1'b1;
          end
        end
      end
      ST_FACTORY: begin
        if (factory_ok) begin
          nxt_state = ST_FACT_FLASH;
        end
      end
      ST_FACT_FLASH: begin
        if (tick_ff && expired(ms_cnt_ff, READY_FLASH_MS)) begin
          nxt_ms_cnt = '0;
          nxt_nfl = nfl_ff + 3'h1;
          if (nfl_ff == 3'(2 * `BLM_FACT_FLASHES - 1)) begin
            nxt_state = ST_RUN;
          end
        end
      end
      ST_RECOVERY: nxt_state = ST_RECOVERY;
      default: nxt_state = ST_RUN;
    endcase
    if (nxt_state != state_ff) begin
      nxt_ms_cnt = '0;
      nxt_nfl = '0;
    end
  end

  // ==========================================
  // led pattern
  always_comb begin
    nxt_led = '0;
    case (state_ff)
      ST_POWERUP: nxt_led = 5'h1F;
      ST_READY_FLASH: nxt_led = {blink_ff, 4'h0};
      ST_RUN: begin
        nxt_led[4] = ctrl_ff[`BLM_CTRL_READY];
        nxt_led[3] = good_cnt_ff != '0;
        nxt_led[2] = sens2_ff & blink_ff & ~ptslave;
        nxt_led[1] = tx_active & blink_ff & ~ptslave;
        nxt_led[0] = nr_cnt_ff != '0;
      end
      ST_HOLD: begin
        nxt_led[0] = 1'b1;
        nxt_led[4] = step_ff == STEP_NETCFG;
        nxt_led[3] = step_ff == STEP_SETUP;
        nxt_led[2] = step_ff == STEP_LEARN;
        nxt_led[1] = step_ff == STEP_TEST;
      end
      ST_TEST: begin
        if (noread_ff) begin
          nxt_led = {4'h0, blink_ff};
        end else begin
          nxt_led = bar(rate_ff);
        end
      end
      ST_LEARN: nxt_led = {2'h0, blink_ff, 2'h0};
      ST_LEARN_OK: nxt_led = 5'h04;
      ST_SETUP: nxt_led = 5'h08;
      ST_NETCFG: nxt_led = 5'h10;
      ST_RESTORE: nxt_led = nfl_ff == 3'h0 ? 5'h1F : 5'h00;
      ST_RECOVERY: nxt_led = {4'h0, blink_ff};
      ST_FACTORY: nxt_led = 5'h00;
      ST_FACT_FLASH: nxt_led = nfl_ff[0] ? 5'h00 : 5'h1F;
      default: nxt_led = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_POWERUP;
      step_ff <= STEP_EXIT;
      ms_cnt_ff <= '0;
      nfl_ff <= '0;
      discard_ff <= 1'b0;
      restq_ff <= 1'b0;
      led_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      ms_cnt_ff <= nxt_ms_cnt;
      nfl_ff <= nxt_nfl;
      discard_ff <= nxt_discard;
      restq_ff <= nxt_restq;
      led_ff <= nxt_led;
    end
  end

  // ==========================================
  // outputs
  assign {led_ready, led_good, led_trigger, led_com, led_status} = led_ff;
  assign test_active = state_ff == ST_TEST;
  assign learn_active = state_ff == ST_LEARN;
  assign learn_discard = discard_ff;
  assign setup_port_only = state_ff == ST_SETUP && ctrl_ff[`BLM_CTRL_LAST_SLAVE];
  assign netcfg_scan = state_ff == ST_NETCFG;
  assign restore_req = restq_ff;
  assign recovery_mode = state_ff == ST_RECOVERY;
  assign factory_req = state_ff == ST_FACTORY;
endmodule

// ==== core/blm_map.svh ====
// constant map of the button and led mode controller
`ifndef BLM_MAP_SVH
`define BLM_MAP_SVH
// ==========================================
// timing
`define BLM_CLK_HZ 50000000
`define BLM_MS_PER_S 1000
`define BLM_S_PER_MIN 60
`define BLM_POWERUP_S 20
`define BLM_TEST_TIMEOUT_MIN 2
`define BLM_LEARN_TIMEOUT_MIN 3
`define BLM_FLASH_MS 100
`define BLM_READY_FLASH_MS 1000
`define BLM_STEP_MS 1500
`define BLM_LEARN_OK_MS 1000
`define BLM_RESTORE_MS 1000
`define BLM_DEBOUNCE_MS 20
`define BLM_FACT_FLASHES 3
`define BLM_BAR_STEP 20
// ==========================================
// register offsets
`define BLM_OFS_CTRL 12'h000
`define BLM_OFS_RATE 12'h004
`define BLM_OFS_STATUS 12'h008
// ==========================================
// control fields
`define BLM_CTRL_TRACK_MODE 0
`define BLM_CTRL_SLAVE 1
`define BLM_CTRL_MASTER 2
`define BLM_CTRL_LAST_SLAVE 3
`define BLM_CTRL_READY 4
`define BLM_CTRL_W 5
`define BLM_CTRL_RST 5'h10
`define BLM_RATE_W 7
// ==========================================
// status fields
`define BLM_ST_STATE_LSB 0
`define BLM_ST_LED_LSB 4
`define BLM_ST_PUSH 9
`define BLM_ST_RESTORE 10
`define BLM_ST_STEP_LSB 11
`endif

// ==== core/blm_pkg.sv ====
// types of the button and led mode controller
package blm_pkg;
  typedef enum logic [3:0] {
    ST_POWERUP, ST_READY_FLASH, ST_RUN, ST_HOLD, ST_TEST, ST_LEARN, ST_LEARN_OK,
    ST_SETUP, ST_NETCFG, ST_RESTORE, ST_RECOVERY, ST_FACTORY, ST_FACT_FLASH
  } blm_state_t;
  typedef enum logic [2:0] {
    STEP_EXIT, STEP_TEST, STEP_LEARN, STEP_SETUP, STEP_NETCFG
  } blm_step_t;
endpackage

// ==== core/blm_debounce.sv ====
// pin synchroniser and debouncer for one button
`timescale 1ns/1ps
`include "blm_map.svh"
module blm_debounce #(
  parameter int DEB_MS = `BLM_DEBOUNCE_MS
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic tick_ms, // one-cycle pulse each millisecond
  input wire logic pin_n, // raw button pin, low when pressed
  output logic held // debounced pressed level
);
  logic sync1_ff, sync2_ff, held_ff, nxt_held;
  logic [7:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_held = held_ff;
    nxt_cnt = cnt_ff;
    if (~sync2_ff == held_ff) begin
      nxt_cnt = '0;
    end else if (tick_ms) begin
      if (cnt_ff >= 8'(DEB_MS - 1)) begin
        nxt_held = ~sync2_ff;
        nxt_cnt = '0;
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      held_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      sync1_ff <= pin_n;
      sync2_ff <= sync1_ff;
      held_ff <= nxt_held;
      cnt_ff <= nxt_cnt;
    end
  end

  assign held = held_ff;
endmodule

// ==== dv/blm_operator.sv ====
// operator model: works the two panel buttons, with contact bounce
`timescale 1ns/1ps
module blm_operator (
  input wire logic pclk, // system clock
  input wire logic want_push, // operator holds push button
  input wire logic want_restore, // operator holds restore button
  output logic push_btn_n, // push pin, low pressed
  output logic restore_btn_n // restore pin, low pressed
);
  logic [3:0] bnc_ff = 4'h0;
  logic [3:0] nxt_bnc;
  logic [1:0] last_ff = 2'h0;
  // contacts chatter for a few cycles after each change
  always_comb begin
    nxt_bnc = (bnc_ff != 4'h0) ? bnc_ff - 4'h1 : 4'h0;
    if (last_ff != {want_push, want_restore}) nxt_bnc = 4'h7;
  end
  always_ff @(posedge pclk) begin
    bnc_ff <= nxt_bnc;
    last_ff <= {want_push, want_restore};
  end
  assign push_btn_n = ~want_push ^ bnc_ff[0];
  assign restore_btn_n = ~want_restore ^ bnc_ff[0];
endmodule

// ==== dv/blm_ctrl_props.sv ====
// port assertions of the front-panel mode controller
`timescale 1ns/1ps
module blm_ctrl_chk #(
  parameter int TICK_CYCLES = 10,
  parameter int POWERUP_MS = 20,
  parameter int TEST_MS = 50,
  parameter int LEARN_MS = 60,
  parameter int LEARN_OK_MS = 4
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pslverr, // apb error
  input wire logic led_ready, // ready led
  input wire logic led_good, // good led
  input wire logic led_trigger, // trigger led
  input wire logic led_com, // com led
  input wire logic led_status, // status led
  input wire logic test_active, // test running
  input wire logic learn_active, // learn running
  input wire logic learn_discard, // learned params dropped
  input wire logic setup_port_only, // setup mode
  input wire logic netcfg_scan, // netconfig mode
  input wire logic restore_req, // adopt box parameters
  input wire logic recovery_mode, // software recovery
  input wire logic factory_req // factory reset
);
  logic [4:0] leds;
  int rst_cnt_ff, tst_cnt_ff, lrn_cnt_ff, nxt_rst_cnt, nxt_tst_cnt, nxt_lrn_cnt;
  assign leds = {led_ready, led_good, led_trigger, led_com, led_status};
  // ==========================================
  // cycle counters since reset and in the test and learn modes
  always_comb begin
    nxt_rst_cnt = (rst_cnt_ff < 1000000) ? rst_cnt_ff + 1 : rst_cnt_ff;
    nxt_tst_cnt = test_active ? tst_cnt_ff + 1 : 0;
    nxt_lrn_cnt = learn_active ? lrn_cnt_ff + 1 : 0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_ff <= 0;
      tst_cnt_ff <= 0;
      lrn_cnt_ff <= 0;
    end else begin
      rst_cnt_ff <= nxt_rst_cnt;
      tst_cnt_ff <= nxt_tst_cnt;
      lrn_cnt_ff <= nxt_lrn_cnt;
    end
  end
  // ==========================================
  // properties
  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pwr_leds;
    rst_cnt_ff == 2 |-> leds == 5'h1F;
  endproperty
  a_pwr_leds: assert property (p_pwr_leds) else $error("leds dark after reset");
  property p_strap_late;
    rst_cnt_ff < (POWERUP_MS - 1) * TICK_CYCLES |-> !recovery_mode && !factory_req;
  endproperty
  a_strap_late: assert property (p_strap_late) else $error("strap mode too early");
  property p_recov_stay;
    recovery_mode |=> recovery_mode;
  endproperty
  a_recov_stay: assert property (p_recov_stay) else $error("recovery left");
  property p_one_fn;
    $onehot0({test_active, learn_active, setup_port_only, netcfg_scan, recovery_mode,
      factory_req});
  endproperty
  a_one_fn: assert property (p_one_fn) else $error("two functions active");
  property p_test_lim;
    tst_cnt_ff <= (TEST_MS + 2) * TICK_CYCLES;
  endproperty
  a_test_lim: assert property (p_test_lim) else $error("test mode overran");
  property p_learn_lim;
    lrn_cnt_ff <= (LEARN_MS + LEARN_OK_MS + 2) * TICK_CYCLES;
  endproperty
  a_learn_lim: assert property (p_learn_lim) else $error("learn mode overran");
  property p_discard;
    learn_discard |-> !learn_active && ($past(learn_active) || $past(learn_active, 2));
  endproperty
  a_discard: assert property (p_discard) else $error("discard outside learn end");
  property p_restore_dark;
    restore_req |-> $past(leds) == 5'h00;
  endproperty
  a_restore_dark: assert property (p_restore_dark) else $error("restore without dark");
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
  c_recov: cover property ($rose(recovery_mode));
  c_fact: cover property ($rose(factory_req));
  c_disc: cover property (learn_discard);
  c_rest: cover property (restore_req);
endmodule
bind blm_ctrl blm_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES), .POWERUP_MS(POWERUP_MS),
  .TEST_MS(TEST_MS), .LEARN_MS(LEARN_MS), .LEARN_OK_MS(LEARN_OK_MS)) u_chk (.pclk, .presetn,
  .psel, .penable, .pslverr, .led_ready, .led_good, .led_trigger, .led_com, .led_status,
  .test_active, .learn_active, .learn_discard, .setup_port_only, .netcfg_scan, .restore_req,
  .recovery_mode, .factory_req);

// ==== dv/blm_ctrl_tb.sv ====
// self-checking bench of the front-panel mode controller
`timescale 1ns/1ps
module blm_ctrl_tb;
  import blm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic sensor_pin = 1'b0, decode_ok = 1'b0, no_read = 1'b0, tx_active = 1'b0;
  logic learn_saved = 1'b0, factory_ok = 1'b0, want_push = 1'b0, want_restore = 1'b0;
  logic pready, pslverr, err, seen, push_btn_n, restore_btn_n, led_ready, led_good;
  logic led_trigger, led_com, led_status, test_active, learn_active, learn_discard;
  logic setup_port_only, netcfg_scan, restore_req, recovery_mode, factory_req;
  logic [4:0] leds, seen5, all5, lit;
  logic [3:0] fn;
  logic [6:0] rate;
  int bad_count = 0, checked = 0, seed = 36, n, k;
  assign leds = {led_ready, led_good, led_trigger, led_com, led_status};
  assign fn = {test_active, learn_active, setup_port_only, netcfg_scan};
  always #10 pclk = ~pclk;
  blm_operator op (.pclk, .want_push, .want_restore, .push_btn_n, .restore_btn_n);
  // one tick per cycle; flash, restore and debounce keep their default spans
  blm_ctrl #(.TICK_CYCLES(1), .POWERUP_MS(200), .TEST_MS(500), .LEARN_MS(600),
    .STEP_MS(80)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .push_btn_n, .restore_btn_n, .sensor_pin, .decode_ok, .no_read, .tx_active, .learn_saved,
    .factory_ok, .led_ready, .led_good, .led_trigger, .led_com, .led_status, .test_active,
    .learn_active, .learn_discard, .setup_port_only, .netcfg_scan, .restore_req,
    .recovery_mode, .factory_req);
  // ==========================================
  // tasks
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_sim();
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-cycle event: 0 decode, 1 no-read, 2 learn saved, else factory done
  task pulse(input int w);
    case (w)
      0: decode_ok <= 1'b1;
      1: no_read <= 1'b1;
      2: learn_saved <= 1'b1;
      default: factory_ok <= 1'b1;
    endcase
    @(posedge pclk);
    {decode_ok, no_read, learn_saved, factory_ok} <= 4'h0;
  endtask
  task see(input int c);
    seen5 = 5'h00;
    all5 = 5'h1F;
    repeat (c) begin
      @(posedge pclk);
      seen5 |= leds;
      all5 &= leds;
    end
  endtask
  task hold(input int c);
    want_push <= 1'b1;
    see(c);
    lit = leds;
    want_push <= 1'b0;
    repeat (60) @(posedge pclk);
  endtask
  task power(input logic p, input logic r);
    presetn <= 1'b0;
    want_push <= p;
    want_restore <= r;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (250) @(posedge pclk);
    want_push <= 1'b0;
    want_restore <= 1'b0;
  endtask
  function automatic logic [4:0] bar(input logic [6:0] r);
    for (int i = 0; i < 5; i++) bar[i] = (r > 7'(20 * i));
  endfunction
  // ==========================================
  // main sequence
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    end_sim();
  end
  initial begin
    power(1'b0, 1'b0);
    rd = 32'h0;
    for (k = 0; k < 600 && rd[3:0] !== ST_RUN; k++) apb(1'b0, 12'h008, 32'h0);
    cmp(rd[3:0], ST_RUN);
    cmp(led_ready, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h10);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    cmp(err, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    cmp({err, rd[30:0]}, 32'h80000000);
    rate = 7'($unsigned($random(seed)) % 101);
    apb(1'b1, 12'h004, {25'h0, rate});
    apb(1'b0, 12'h004, 32'h0);
    cmp(rd, {25'h0, rate});
    pulse(0);
    see(10);
    cmp(seen5[3], 1'b1);
    sensor_pin <= 1'b1;
    tx_active <= 1'b1;
    see(210);
    cmp(seen5[2:1], 2'h3);
    apb(1'b1, 12'h000, 32'h13);
    repeat (10) @(posedge pclk);
    see(210);
    cmp(seen5[2:1], 2'h0);
    sensor_pin <= 1'b0;
    tx_active <= 1'b0;
    apb(1'b1, 12'h000, 32'h1C);
    for (int s = 0; s < 5; s++) begin
      hold(40 + 80 * s);
      cmp(seen5[0], 1'b1);
      cmp(lit, (5'h01 << s) | 5'h01);
      cmp(fn, (s == 0) ? 4'h0 : 4'(4'h8 >> (s - 1)));
      if (s == 1) begin
        cmp(leds, bar(rate));
        pulse(1);
        repeat (3) @(posedge pclk);
        see(210);
        cmp(seen5, 5'h01);
        pulse(0);
      end
      if (s == 2) begin
        see(210);
        cmp(seen5[2] & ~all5[2], 1'b1);
        pulse(2);
        repeat (3) @(posedge pclk);
        see(30);
        cmp(all5[2], 1'b1);
        repeat (1000) @(posedge pclk);
      end else if (s != 0) begin
        hold(40);
      end
      cmp(fn, 4'h0);
    end
    hold(120);
    apb(1'b1, 12'h004, 32'd20);
    repeat (5) @(posedge pclk);
    cmp(leds, bar(7'd20));
    for (k = 0; k < 650 && test_active === 1'b1; k++) @(posedge pclk);
    cmp({test_active, k > 350}, 2'h1);
    hold(200);
    cmp(learn_active, 1'b1);
    for (k = 0; k < 700 && learn_discard !== 1'b1; k++) @(posedge pclk);
    cmp(learn_discard, 1'b1);
    want_restore <= 1'b1;
    see(70);
    cmp(seen5, 5'h1F);
    want_restore <= 1'b0;
    for (k = 0; k < 2500 && restore_req !== 1'b1; k++) @(posedge pclk);
    cmp(restore_req, 1'b1);
    repeat (5) @(posedge pclk);
    cmp(led_ready, 1'b1);
    power(1'b1, 1'b0);
    repeat (50) @(posedge pclk);
    cmp({recovery_mode, factory_req}, 2'h2);
    power(1'b1, 1'b1);
    cmp({recovery_mode, factory_req}, 2'h1);
    pulse(3);
    n = 0;
    seen = &leds;
    repeat (6200) begin
      @(posedge pclk);
      if (&leds === 1'b1 && seen === 1'b0) n++;
      seen = &leds;
    end
    cmp(n, 3);
    end_sim();
  end
endmodule
